// ### rtl/timer_pkg.sv
// Constants and carrier types for the general timer block.
// Assumes a single 20 MHz system clock and an AXI4-Lite register port.
package timer_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] OFF_CONFIG = 12'h000;
  localparam logic [11:0] OFF_MODE = 12'h004;
  localparam logic [11:0] OFF_CONTROL = 12'h00C;
  localparam logic [11:0] OFF_MASK = 12'h018;
  localparam logic [11:0] OFF_RAW = 12'h01C;
  localparam logic [11:0] OFF_MASKED = 12'h020;
  localparam logic [11:0] OFF_CLEAR = 12'h024;
  localparam logic [11:0] OFF_LOAD = 12'h028;
  localparam logic [11:0] OFF_MATCH = 12'h030;
  localparam logic [11:0] OFF_PRESCALE = 12'h038;
  localparam logic [11:0] OFF_VALUE = 12'h048;

  // ----------------------------------------
  // Field encodings and positions
  // ----------------------------------------
  localparam logic [2:0] CFG_32BIT = 3'h0;
  localparam logic [2:0] CFG_RTC = 3'h1;
  localparam logic [2:0] CFG_16BIT = 3'h4;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;
  localparam int MODE_CMR_BIT = 2;
  localparam int MODE_AMS_BIT = 3;
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_EVT_LSB = 2;
  localparam int CTL_RTC_BIT = 4;
  localparam int CTL_INV_BIT = 6;
  localparam logic [1:0] EVT_RISE = 2'h0;
  localparam logic [1:0] EVT_FALL = 2'h1;
  localparam int FLG_TIMEOUT = 0;
  localparam int FLG_CMATCH = 1;
  localparam int FLG_CEVENT = 2;
  localparam int FLG_RTC = 3;

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [31:0] LOAD_RST = 32'hFFFFFFFF;
  localparam logic [31:0] MATCH_RST = 32'hFFFFFFFF;
  localparam logic [31:0] COUNT_RST = 32'hFFFFFFFF;
  localparam logic [31:0] RTC_START = 32'h00000001;
  localparam int RTC_DIV_DEFAULT = 32768;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Carrier
  // ----------------------------------------
  typedef struct packed {
    logic rise;
    logic fall;
  } edge_t;

endpackage

// ### rtl/edge_sense.sv
// Edge qualifier for the capture/compare pin.
// Assumes the pin is already synchronous to aclk.
`timescale 1ns/1ps
module edge_sense (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output timer_pkg::edge_t edges
);

  typedef struct packed {
    logic [2:0] smp;
  } sense_t;

  sense_t q;
  sense_t d;

  // ----------------------------------------
  // Sampling
  // ----------------------------------------
  always_comb begin
    d = q;
    d.smp = {q.smp[1:0], pin};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // New level must be seen on two samples before the edge counts
  assign edges.rise = q.smp[0] & q.smp[1] & ~q.smp[2]; // R25
  assign edges.fall = ~q.smp[0] & ~q.smp[1] & q.smp[2]; // R25

endmodule

// ### rtl/general_timer_module.sv
// General timer with edge count, edge time, PWM, one-shot/periodic and RTC.
// Assumes an AXI4-Lite master on aclk and a pin synchronous to aclk.
//
// How it works
// R1 - Edge input must hold two clocks
// R2 - Prescaler unused in capture and PWM
// R3 - Capture select 0 gives edge counting
// R4 - Each qualifying edge decrements counter once
// R5 - Count reaching match sets match flag
// R6 - Match reloads, clears enable, ignores edges
// R7 - Capture select 1 gives free-running down-counter
// R8 - Selected edge captures count, sets flag
// R9 - Edge time keeps counting, reloads at zero
// R10 - Captured value held until next edge
// R11 - PWM needs alternate, capture, mode codes
// R12 - PWM counts down, reloads, no flags
// R13 - PWM active at load, inactive at match
// R14 - Invert bit flips PWM polarity
// R15 - Software enables peripheral clock first
// R16 - Software sequence for 32-bit timer
// R17 - One-shot stops, periodic keeps counting
// R18 - Write one clears status flags
// R19 - Software sequence for RTC use
// R20 - RTC needs 32.768 kHz on pin
// R21 - RTC match sets flag, keeps counting
// R22 - Software sequence for 16-bit timer
// R23 - Capture modes use mode field three
// R24 - Load write while running applies next cycle (only in edge time, PWM and timed modes; edge count and RTC keep the count)
// R25 - Edges found by comparing held samples
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module general_timer_module #(
  parameter int RTC_DIV = timer_pkg::RTC_DIV_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic capture_compare_pin_in,
  output logic capture_compare_pin_out,
  output logic capture_compare_pin_oe
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (RTC_DIV < 2) begin : g_bad_div
    $error("RTC_DIV must be at least 2");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_have;
    logic w_have;
    logic bvalid;
    logic rvalid;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] timer_config_register;
    logic [3:0] timer_mode_register;
    logic [6:0] timer_control_register;
    logic [3:0] interrupt_mask_register;
    logic [3:0] raw_status_register;
    logic [31:0] interval_load_register;
    logic [31:0] match_register;
    logic [7:0] prescale_register;
    logic [31:0] count;
    logic [7:0] pre_count;
    logic [31:0] captured;
    logic [31:0] rtc_div;
    logic pwm_active;
    logic pwm_out;
    logic pwm_oe;
  } state_t;

  localparam state_t STATE_RST = '{
    interval_load_register: timer_pkg::LOAD_RST,
    match_register: timer_pkg::MATCH_RST,
    count: timer_pkg::COUNT_RST,
    captured: timer_pkg::COUNT_RST,
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    default: '0
  };

  state_t q;
  state_t d;
  timer_pkg::edge_t edges;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic edge_hit(input timer_pkg::edge_t e, input logic [1:0] sel);
    logic hit;
    unique case (sel)
      timer_pkg::EVT_RISE: hit = e.rise;
      timer_pkg::EVT_FALL: hit = e.fall;
      default: hit = e.rise | e.fall;
    endcase
    return hit;
  endfunction

  edge_sense u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(capture_compare_pin_in),
    .edges(edges)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [31:0] rd;
    logic [11:0] wa;
    logic [11:0] ra;
    logic [3:0] set_flags;
    logic [3:0] clr_flags;
    logic load_written;
    logic en;
    logic is16;
    logic is32;
    logic isrtc;
    logic cmr;
    logic ams;
    logic [1:0] mfield;
    logic ecount;
    logic etime;
    logic pwm;
    logic timed;
    logic hit;
    logic [31:0] reload;
    logic [31:0] cur;
    logic [31:0] mval;
    logic zero;
    wv = '0;
    rd = '0;
    wa = '0;
    ra = '0;
    set_flags = '0;
    clr_flags = '0;
    load_written = 1'b0;
    d = q;

    // AXI write channels, taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (d.aw_have && d.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = timer_pkg::RESP_OKAY;
      wa = {d.awaddr[11:2], 2'b00};
      unique case (wa)
        timer_pkg::OFF_CONFIG: begin
          wv = merge({29'h0, q.timer_config_register}, d.wdata, d.wstrb);
          d.timer_config_register = wv[2:0];
        end
        timer_pkg::OFF_MODE: begin
          wv = merge({28'h0, q.timer_mode_register}, d.wdata, d.wstrb);
          d.timer_mode_register = wv[3:0];
        end
        timer_pkg::OFF_CONTROL: begin
          wv = merge({25'h0, q.timer_control_register}, d.wdata, d.wstrb);
          d.timer_control_register = wv[6:0];
        end
        timer_pkg::OFF_MASK: begin
          wv = merge({28'h0, q.interrupt_mask_register}, d.wdata, d.wstrb);
          d.interrupt_mask_register = wv[3:0];
        end
        timer_pkg::OFF_CLEAR: begin
          wv = merge(32'h0, d.wdata, d.wstrb);
          clr_flags = wv[3:0]; // R18
        end
        timer_pkg::OFF_LOAD: begin
          d.interval_load_register = merge(q.interval_load_register, d.wdata, d.wstrb);
          load_written = 1'b1;
        end
        timer_pkg::OFF_MATCH: begin
          d.match_register = merge(q.match_register, d.wdata, d.wstrb);
        end
        timer_pkg::OFF_PRESCALE: begin
          wv = merge({24'h0, q.prescale_register}, d.wdata, d.wstrb);
          d.prescale_register = wv[7:0];
        end
        timer_pkg::OFF_RAW, timer_pkg::OFF_MASKED, timer_pkg::OFF_VALUE: begin
          d.bresp = timer_pkg::RESP_OKAY;
        end
        default: begin
          d.bresp = timer_pkg::RESP_SLVERR;
        end
      endcase
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;

    // Mode decode from the settled register values
    en = q.timer_control_register[timer_pkg::CTL_EN_BIT];
    is16 = q.timer_config_register == timer_pkg::CFG_16BIT;
    is32 = q.timer_config_register == timer_pkg::CFG_32BIT;
    isrtc = q.timer_config_register == timer_pkg::CFG_RTC;
    cmr = q.timer_mode_register[timer_pkg::MODE_CMR_BIT];
    ams = q.timer_mode_register[timer_pkg::MODE_AMS_BIT];
    mfield = q.timer_mode_register[1:0];
    ecount = is16 && mfield == timer_pkg::MODE_CAPTURE && !cmr; // R3
    etime = is16 && mfield == timer_pkg::MODE_CAPTURE && cmr; // R7
    pwm = is16 && ams && !cmr && mfield == timer_pkg::MODE_PERIODIC; // R11
    timed = (is32 || (is16 && !ams)) &&
            (mfield == timer_pkg::MODE_ONESHOT || mfield == timer_pkg::MODE_PERIODIC);
    hit = edge_hit(edges, q.timer_control_register[timer_pkg::CTL_EVT_LSB +: 2]); // R1
    reload = is16 ? {16'h0, q.interval_load_register[15:0]} : q.interval_load_register;
    cur = is16 ? {16'h0, q.count[15:0]} : q.count;
    mval = is16 ? {16'h0, q.match_register[15:0]} : q.match_register;
    zero = cur == 32'h0;

    // ----------------------------------------
    // Counter engine
    // ----------------------------------------
    if (!en) begin
      // Idle counter tracks its start value so enable starts from it
      d.count = isrtc ? timer_pkg::RTC_START : reload;
      d.pre_count = q.prescale_register;
      d.rtc_div = '0;
      d.pwm_active = 1'b0;
    end else if (ecount) begin
      if (hit) begin
        if (cur - 32'h1 == mval) begin
          set_flags[timer_pkg::FLG_CMATCH] = 1'b1; // R5
          d.count = reload; // R6
          d.timer_control_register[timer_pkg::CTL_EN_BIT] = 1'b0; // R6
        end else begin
          d.count = cur - 32'h1; // R4
        end
      end
    end else if (etime) begin
      if (hit) begin
        d.captured = cur; // R8 R10
        set_flags[timer_pkg::FLG_CEVENT] = 1'b1; // R8
      end
      d.count = zero ? reload : cur - 32'h1; // R9 R2
    end else if (pwm) begin
      d.count = zero ? reload : cur - 32'h1; // R12 R2
      if (cur == reload) begin
        d.pwm_active = 1'b1; // R13
      end else if (cur == mval) begin
        d.pwm_active = 1'b0; // R13
      end
    end else if (timed) begin
      if (is16 && q.pre_count != 8'h0) begin
        d.pre_count = q.pre_count - 8'h1;
      end else begin
        d.pre_count = q.prescale_register;
        if (zero) begin
          d.count = reload;
          set_flags[timer_pkg::FLG_TIMEOUT] = 1'b1;
          if (mfield == timer_pkg::MODE_ONESHOT) begin
            d.timer_control_register[timer_pkg::CTL_EN_BIT] = 1'b0; // R17
          end
        end else begin
          d.count = cur - 32'h1; // R17
        end
      end
    end else if (isrtc) begin
      // Rising edges of the slow input are divided down to one tick
      if (edges.rise) begin
        if (q.rtc_div == 32'(RTC_DIV - 1)) begin
          d.rtc_div = '0;
          if (q.count == q.match_register) begin
            d.count = '0; // R21
            set_flags[timer_pkg::FLG_RTC] = 1'b1; // R21
          end else begin
            d.count = q.count + 32'h1;
          end
        end else begin
          d.rtc_div = q.rtc_div + 32'h1;
        end
      end
    end

    // A new load value while running in edge time, PWM or timed mode replaces the count next cycle
    if (load_written && en && (etime || pwm || timed)) begin
      d.count = is16 ? {16'h0, d.interval_load_register[15:0]}
                     : d.interval_load_register; // R24
    end

    // Hardware set wins over a simultaneous software clear
    d.raw_status_register = (q.raw_status_register & ~clr_flags) | set_flags; // R18

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    d.pwm_oe = pwm;
    d.pwm_out = d.pwm_active ^ d.timer_control_register[timer_pkg::CTL_INV_BIT]; // R14

    // ----------------------------------------
    // AXI read channel
    // ----------------------------------------
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = timer_pkg::RESP_OKAY;
      ra = {s_axi_araddr[11:2], 2'b00};
      unique case (ra)
        timer_pkg::OFF_CONFIG: rd = {29'h0, q.timer_config_register};
        timer_pkg::OFF_MODE: rd = {28'h0, q.timer_mode_register};
        timer_pkg::OFF_CONTROL: rd = {25'h0, q.timer_control_register};
        timer_pkg::OFF_MASK: rd = {28'h0, q.interrupt_mask_register};
        timer_pkg::OFF_RAW: rd = {28'h0, q.raw_status_register};
        timer_pkg::OFF_MASKED: begin
          rd = {28'h0, q.raw_status_register & q.interrupt_mask_register}; // R5
        end
        timer_pkg::OFF_CLEAR: rd = 32'h0;
        timer_pkg::OFF_LOAD: rd = q.interval_load_register;
        timer_pkg::OFF_MATCH: rd = q.match_register;
        timer_pkg::OFF_PRESCALE: rd = {24'h0, q.prescale_register};
        timer_pkg::OFF_VALUE: rd = etime ? q.captured : cur; // R10
        default: begin
          rd = 32'h0;
          d.rresp = timer_pkg::RESP_SLVERR;
        end
      endcase
      d.rdata = rd;
    end
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs, all from flops
  // ----------------------------------------
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign capture_compare_pin_out = q.pwm_out;
  assign capture_compare_pin_oe = q.pwm_oe;

endmodule

// ### bench/pin_source.sv
// Far-side model of the capture/compare pin source.
// Assumes one clock; the bench calls pulses() through the instance.
`timescale 1ns/1ps
module pin_source (
  input wire logic aclk,
  output logic pin
);
  initial pin = 1'b0;
  // Each level is held three or more clocks, so every edge qualifies
  task automatic pulses(input int n);
    int h;
    repeat (2 * n) begin
      h = 2 + ($urandom % 3);
      @(posedge aclk);
      pin <= ~pin;
      repeat (h) @(posedge aclk);
    end
  endtask
endmodule

// ### bench/timer_checker_sva.sv
// Port-level checker for the general timer.
// Assumes it is bound to general_timer_module.
`timescale 1ns/1ps
module timer_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic capture_compare_pin_out,
  input wire logic capture_compare_pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_b_after_take;
    s_wr_taken |=> s_axi_bvalid;
  endproperty
  a_b_after_take: assert property (p_b_after_take) else $error("no write response");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_after_take;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_r_after_take: assert property (p_r_after_take) else $error("no read data");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data changed");
  property p_w_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken while busy");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read not retired");
  property p_rd_unmapped;
    s_rd_taken and s_axi_araddr > 12'h04B |=>
      s_axi_rresp == timer_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
  property p_reset_pin;
    $rose(aresetn) |-> !capture_compare_pin_oe && !capture_compare_pin_out;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("pin active after reset");
endmodule
bind general_timer_module timer_checker timer_checker_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .capture_compare_pin_out(capture_compare_pin_out),
  .capture_compare_pin_oe(capture_compare_pin_oe)
);

// ### bench/general_timer_module_bench.sv
// Self-checking bench for the general timer.
// Assumes the pin source model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module general_timer_module_bench;
  localparam int RDIV = 4;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, pin, pout, poe;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, v1;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] wstrb;
  logic [15:0] ld, mt;
  int miscompares, check_count, hi, k, pe, ne, seed_sink;
  general_timer_module #(.RTC_DIV(RDIV)) general_timer_module_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capture_compare_pin_in(pin), .capture_compare_pin_out(pout),
    .capture_compare_pin_oe(poe)
  );
  pin_source pin_source_i (.aclk(aclk), .pin(pin));
  // ----------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n > 1) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 200);
    rs = bresp;
    bready <= 1'b0;
    if (n >= 200) miscompares++;
  endtask
  task automatic rdv(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (n > 1) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 200);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n >= 200) miscompares++;
  endtask
  // Cycles high over two PWM periods; counter spans load down to zero
  function automatic int pwm_hi(input int l, input int m, input int inv);
    return 2 * (inv != 0 ? m + 1 : l - m);
  endfunction
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    print_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed_sink = $urandom(32'h2F46F03E);
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (general_timer_module_i.s_axi_rdata[i]) if (i < 1) begin
      rdv(timer_pkg::OFF_VALUE);
      `CHK("value reset", timer_pkg::COUNT_RST, rd)
      rdv(timer_pkg::OFF_LOAD);
      `CHK("load reset", timer_pkg::LOAD_RST, rd)
    end
    wr(timer_pkg::OFF_LOAD, 32'h0, 4'h2);
    rdv(timer_pkg::OFF_LOAD);
    `CHK("strobe merge", 32'hFFFF00FF, rd)
    rdv(12'h0FC);
    `CHK("unmapped read resp", timer_pkg::RESP_SLVERR, rs)
    wr(12'h0F0, 32'h0000FFFF);
    `CHK("unmapped write resp", timer_pkg::RESP_SLVERR, rs)
    // Edge counting for event codes 0, 1 and 2; extra edges after the match are ignored
    for (int e = 0; e < 3; e++) begin
      k = 2 + $urandom % 4;
      ne = (e == 2) ? 2 * k : k;
      pe = (e == 2) ? 2 * (k - 1) : k - 1;
      ld = 16'h0100 + 16'($urandom % 32'h0F00);
      mt = ld - 16'(ne);
      wr(timer_pkg::OFF_CONTROL, 32'h0);
      wr(timer_pkg::OFF_CONFIG, 32'(timer_pkg::CFG_16BIT));
      wr(timer_pkg::OFF_MODE, 32'(timer_pkg::MODE_CAPTURE));
      wr(timer_pkg::OFF_LOAD, 32'(ld));
      wr(timer_pkg::OFF_MATCH, 32'(mt));
      wr(timer_pkg::OFF_MASK, 32'h2);
      wr(timer_pkg::OFF_CONTROL, 32'(e) << timer_pkg::CTL_EVT_LSB | 32'h1);
      pin_source_i.pulses(k - 1);
      rdv(timer_pkg::OFF_VALUE);
      `CHK("edge count", ld - 16'(pe), rd[15:0])
      rdv(timer_pkg::OFF_RAW);
      `CHK("early match", 1'b0, rd[timer_pkg::FLG_CMATCH])
      pin_source_i.pulses(1);
      rdv(timer_pkg::OFF_MASKED);
      `CHK("masked match", 1'b1, rd[timer_pkg::FLG_CMATCH])
      rdv(timer_pkg::OFF_CONTROL);
      `CHK("self disable", 1'b0, rd[timer_pkg::CTL_EN_BIT])
      wr(timer_pkg::OFF_CLEAR, 32'h2);
      pin_source_i.pulses(2);
      rdv(timer_pkg::OFF_RAW);
      `CHK("cleared match", 4'h0, rd[3:0])
      rdv(timer_pkg::OFF_VALUE);
      `CHK("reloaded", ld, rd[15:0])
    end
    // Edge time: captures held, reload value change applies while running
    wr(timer_pkg::OFF_MODE, 32'(timer_pkg::MODE_CAPTURE) | 32'h4);
    ld = 16'hF000 | 16'($urandom % 32'h0FFF);
    wr(timer_pkg::OFF_LOAD, 32'(ld));
    wr(timer_pkg::OFF_CONTROL, 32'h1);
    pin_source_i.pulses(1);
    rdv(timer_pkg::OFF_VALUE);
    v1 = rd;
    `CHK("capture below load", 1'b1, rd[15:0] < ld)
    rdv(timer_pkg::OFF_RAW);
    `CHK("capture flag", 1'b1, rd[timer_pkg::FLG_CEVENT])
    rdv(timer_pkg::OFF_VALUE);
    `CHK("capture held", v1, rd)
    pin_source_i.pulses(1);
    rdv(timer_pkg::OFF_VALUE);
    `CHK("new capture", 1'b1, rd[15:0] < v1[15:0])
    wr(timer_pkg::OFF_LOAD, 32'h40);
    pin_source_i.pulses(1);
    rdv(timer_pkg::OFF_VALUE);
    `CHK("short interval", 1'b1, rd[15:0] <= 16'h0040)
    wr(timer_pkg::OFF_CONTROL, 32'h0);
    wr(timer_pkg::OFF_CLEAR, 32'hF);
    // PWM with both polarities; a prescale value must not stretch the period
    wr(timer_pkg::OFF_PRESCALE, 32'hFF);
    wr(timer_pkg::OFF_MODE, 32'(timer_pkg::MODE_PERIODIC) | 32'h8);
    for (int inv = 0; inv < 2; inv++) begin
      ld = 16'(16 + $urandom % 32);
      mt = 16'(2 + $urandom % (ld - 4));
      wr(timer_pkg::OFF_LOAD, 32'(ld));
      wr(timer_pkg::OFF_MATCH, 32'(mt));
      wr(timer_pkg::OFF_CONTROL, 32'(inv) << timer_pkg::CTL_INV_BIT | 32'h1);
      repeat (3 * (ld + 1)) @(posedge aclk);
      hi = 0;
      repeat (2 * (ld + 1)) begin
        @(posedge aclk);
        if (pout === 1'b1) hi++;
      end
      `CHK("pwm high cycles", pwm_hi(ld, mt, inv), hi)
      `CHK("pwm drive", 1'b1, poe)
      wr(timer_pkg::OFF_CONTROL, 32'h0);
    end
    rdv(timer_pkg::OFF_RAW);
    `CHK("pwm flags", 4'h0, rd[3:0])
    // One-shot then periodic, 32-bit, then prescaled periodic, 16-bit
    wr(timer_pkg::OFF_CONFIG, 32'(timer_pkg::CFG_32BIT));
    for (int m = 1; m < 3; m++) begin
      wr(timer_pkg::OFF_MODE, 32'(m));
      wr(timer_pkg::OFF_LOAD, 32'd30);
      wr(timer_pkg::OFF_CONTROL, 32'h1);
      repeat (80) @(posedge aclk);
      rdv(timer_pkg::OFF_RAW);
      `CHK("timeout flag", 1'b1, rd[timer_pkg::FLG_TIMEOUT])
      rdv(timer_pkg::OFF_CONTROL);
      `CHK("enable after timeout", m == 2, rd[timer_pkg::CTL_EN_BIT])
      wr(timer_pkg::OFF_CONTROL, 32'h0);
      wr(timer_pkg::OFF_CLEAR, 32'h1);
      rdv(timer_pkg::OFF_RAW);
      `CHK("timeout cleared", 1'b0, rd[timer_pkg::FLG_TIMEOUT])
    end
    wr(timer_pkg::OFF_CONFIG, 32'(timer_pkg::CFG_16BIT));
    wr(timer_pkg::OFF_PRESCALE, 32'h3);
    wr(timer_pkg::OFF_CONTROL, 32'h1);
    for (int t = 0; t < 2; t++) begin
      repeat (40 + 60 * t) @(posedge aclk);
      rdv(timer_pkg::OFF_RAW);
      `CHK("prescaled timeout", t, rd[timer_pkg::FLG_TIMEOUT])
    end
    wr(timer_pkg::OFF_CONTROL, 32'h0);
    // Clock-calendar count: two ticks from the start value reach match 2
    wr(timer_pkg::OFF_CONFIG, 32'(timer_pkg::CFG_RTC));
    wr(timer_pkg::OFF_MATCH, 32'd2);
    wr(timer_pkg::OFF_CONTROL, 32'h11);
    pin_source_i.pulses(2 * RDIV);
    rdv(timer_pkg::OFF_RAW);
    `CHK("rtc flag", 1'b1, rd[timer_pkg::FLG_RTC])
    rdv(timer_pkg::OFF_CONTROL);
    `CHK("rtc runs on", 1'b1, rd[timer_pkg::CTL_EN_BIT])
    wr(timer_pkg::OFF_CLEAR, 32'h8);
    rdv(timer_pkg::OFF_RAW);
    `CHK("rtc cleared", 1'b0, rd[timer_pkg::FLG_RTC])
    print_verdict();
  end
endmodule
